// ===== grc_top.sv
`timescale 1ns/1ns
// How it works
// - Input 0 polarity bit: cleared means active low, set means active high.
// - Input 0 function: 00 plain input, 01 tracking enable, 1x reserved.
// - Pins 2 and 3 function: 00 input, 10 open drain, 11 push pull.
// - For an input pin the mode bit turns debouncing on or off.
// - For an output pin the mode bit drives active or passive level.
// - Pins 2 and 3 polarity sets active level for input and output use.
// - Pin 4 is input only; upper four register bits are unused.
// - Voltage pin selector: 00 none, 01 pin 1, 10 pin 2, 11 pin 4.
// - Active-to-passive selects set A, passive-to-active selects set B.
// - Rail transitions use the controlling pin's own polarity bit.
// - Voltage select bit: cleared ramps to set A, set ramps to set B.
// - Pull-down disable bit: cleared keeps pull-down on while rail is off, once out of reset.
// - Rail A enabled on pin passive-to-active, disabled on active-to-passive.
// - Rail A enable bit: cleared disables, set enables.
// - Rail B uses the same pin-edge enable scheme as rail A.
// - Shared debounce code: none, 0.1, 1, 10, 50, 250, 500, 1000 ms.
// - Rail ramp steps 10 mV per interval of 4.0 down to 0.5 us; the fastest code counts 12 cycles, 0.48 us at 25 MHz.
module grc_top
    import grc_pkg::*;
#(
    parameter int unsigned DEB_CYC_1 = DEB_C1,
    parameter int unsigned DEB_CYC_2 = DEB_C2,
    parameter int unsigned DEB_CYC_3 = DEB_C3,
    parameter int unsigned DEB_CYC_4 = DEB_C4,
    parameter int unsigned DEB_CYC_5 = DEB_C5,
    parameter int unsigned DEB_CYC_6 = DEB_C6,
    parameter int unsigned DEB_CYC_7 = DEB_C7
)(
    input  wire logic            clk,
    input  wire logic            rstn,
    input  grc_bus_req_type      bus_req,
    output logic [7:0]           reg_rdata,
    input  wire logic            pin0_in,
    input  wire logic            pin1_in,
    input  wire logic            pin2_in,
    output logic                 pin2_out,
    output logic                 pin2_oe_n,
    input  wire logic            pin3_in,
    output logic                 pin3_out,
    output logic                 pin3_oe_n,
    input  wire logic            pin4_in,
    output logic                 track_en,
    output logic                 rail_a_on,
    output logic                 rail_a_volt_set_sel,
    output logic                 rail_a_pulldown_on,
    output logic                 rail_a_ramp_step,
    output logic                 rail_b_on,
    output logic                 rail_b_volt_set_sel,
    output logic                 rail_b_pulldown_on,
    output logic                 rail_b_ramp_step
);
    localparam int unsigned DEB_TABLE [8] = '{
        0, DEB_CYC_1, DEB_CYC_2, DEB_CYC_3, DEB_CYC_4, DEB_CYC_5, DEB_CYC_6, DEB_CYC_7
    };

    logic [7:0]          control_r;
    logic [7:0]          pins01_r;
    logic [7:0]          pins23_r;
    logic [NIB_W-1:0]    pin4_r;
    logic [7:0]          rdata_r;
    logic                track_r;
    logic                pin2_out_r;
    logic                pin2_oe_n_r;
    logic                pin3_out_r;
    logic                pin3_oe_n_r;

    grc_pin_cfg_type     pin_cfg [NUM_PINS];
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] pin_is_in;
    logic [NUM_PINS-1:0] pin_act;
    logic [NUM_PINS-1:0] pin_deb_on;
    grc_deb_cnt_type     deb_limit;
    logic [2:0]          deb_code;

    logic                wr_control;
    logic                wr_pins01;
    logic                wr_pins23;
    logic                wr_pin4;
    logic                wr_rail_a;
    logic                wr_rail_b;
    logic [7:0]          rdata_nxt;

    grc_rail_ctrl_type   rail_a_ctrl;
    grc_rail_ctrl_type   rail_b_ctrl;
    logic                p2_drive_lvl;
    logic                p3_drive_lvl;
    logic                p2_od;
    logic                p3_od;
    logic                p2_pp;
    logic                p3_pp;

    // Write decode.
    assign wr_control = bus_req.we && (bus_req.addr == OFF_CONTROL);
    assign wr_pins01  = bus_req.we && (bus_req.addr == OFF_PINS_0_1);
    assign wr_pins23  = bus_req.we && (bus_req.addr == OFF_PINS_2_3);
    assign wr_pin4    = bus_req.we && (bus_req.addr == OFF_PIN_4);
    assign wr_rail_a  = bus_req.we && (bus_req.addr == OFF_RAIL_A);
    assign wr_rail_b  = bus_req.we && (bus_req.addr == OFF_RAIL_B);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            control_r <= RST_CONTROL;
            pins01_r  <= RST_PINS;
            pins23_r  <= RST_PINS;
            pin4_r    <= RST_PIN_4;
        end else begin
            if (wr_control) begin
                control_r <= bus_req.wdata;
            end
            if (wr_pins01) begin
                pins01_r <= bus_req.wdata;
            end
            if (wr_pins23) begin
                pins23_r <= bus_req.wdata;
            end
            if (wr_pin4) begin
                pin4_r <= bus_req.wdata[NIB_W-1:0];
            end
        end
    end

    // Per-pin configuration nibbles.
    assign pin_cfg[PIN_0] = grc_pin_cfg_type'(pins01_r[NIB_W-1:0]);
    assign pin_cfg[PIN_1] = grc_pin_cfg_type'(pins01_r[2*NIB_W-1:NIB_W]);
    assign pin_cfg[PIN_2] = grc_pin_cfg_type'(pins23_r[NIB_W-1:0]);
    assign pin_cfg[PIN_3] = grc_pin_cfg_type'(pins23_r[2*NIB_W-1:NIB_W]);
    assign pin_cfg[PIN_4] = grc_pin_cfg_type'(pin4_r);

    assign pin_raw = {pin4_in, pin3_in, pin2_in, pin1_in, pin0_in};

    // Only pins 2 and 3 can drive; any other code, reserved ones included, leaves a pin an input.
    assign pin_is_in[PIN_0] = 1'b1;
    assign pin_is_in[PIN_1] = 1'b1;
    assign pin_is_in[PIN_2] = !pin_cfg[PIN_2].func[1];
    assign pin_is_in[PIN_3] = !pin_cfg[PIN_3].func[1];
    assign pin_is_in[PIN_4] = 1'b1;

    assign deb_code  = control_r[CTL_DEB_MSB:CTL_DEB_LSB];
    assign deb_limit = grc_deb_cnt_type'(DEB_TABLE[deb_code]);

    genvar k;
    generate
        for (k = 0; k < NUM_PINS; k++) begin : g_pin
            assign pin_deb_on[k] = pin_is_in[k] && pin_cfg[k].mode;
            // Active means an input pin's level equals its polarity bit; a pin set to drive is never active.
            assign pin_act[k] = pin_is_in[k]
                                && (pin_lvl[k] == pin_cfg[k].polarity);

            grc_debounce #(
                .CNT_W (DEB_CNT_W)
            ) u_deb (
                .clk     (clk),
                .rstn    (rstn),
                .pin_raw (pin_raw[k]),
                .deb_on  (pin_deb_on[k]),
                .limit   (deb_limit),
                .level   (pin_lvl[k])
            );
        end
    endgenerate

    // Output drive for pins 2 and 3.
    assign p2_drive_lvl = pin_cfg[PIN_2].mode ? pin_cfg[PIN_2].polarity
                                              : !pin_cfg[PIN_2].polarity;
    assign p3_drive_lvl = pin_cfg[PIN_3].mode ? pin_cfg[PIN_3].polarity
                                              : !pin_cfg[PIN_3].polarity;
    assign p2_od = pin_cfg[PIN_2].func == FUNC_OD_OUT;
    assign p3_od = pin_cfg[PIN_3].func == FUNC_OD_OUT;
    assign p2_pp = pin_cfg[PIN_2].func == FUNC_PP_OUT;
    assign p3_pp = pin_cfg[PIN_3].func == FUNC_PP_OUT;

    // Open drain only ever pulls low; a high level is left to the external pull-up.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin2_out_r  <= 1'b0;
            pin2_oe_n_r <= 1'b1;
            pin3_out_r  <= 1'b0;
            pin3_oe_n_r <= 1'b1;
        end else begin
            pin2_out_r  <= p2_pp && p2_drive_lvl;
            pin2_oe_n_r <= !(p2_pp || (p2_od && !p2_drive_lvl));
            pin3_out_r  <= p3_pp && p3_drive_lvl;
            pin3_oe_n_r <= !(p3_pp || (p3_od && !p3_drive_lvl));
        end
    end

    assign pin2_out  = pin2_out_r;
    assign pin2_oe_n = pin2_oe_n_r;
    assign pin3_out  = pin3_out_r;
    assign pin3_oe_n = pin3_oe_n_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            track_r <= 1'b0;
        end else begin
            track_r <= (pin_cfg[PIN_0].func == FUNC_TRACK) && pin_act[PIN_0];
        end
    end

    assign track_en = track_r;

    grc_rail #(
        .STEP_W (STEP_CNT_W)
    ) u_rail_a (
        .clk         (clk),
        .rstn        (rstn),
        .wr_en       (wr_rail_a),
        .wr_data     (bus_req.wdata),
        .pin_act     (pin_act),
        .slew_code   (control_r[CTL_SLEW_A_MSB:CTL_SLEW_A_LSB]),
        .ctrl        (rail_a_ctrl),
        .pulldown_on (rail_a_pulldown_on),
        .ramp_step   (rail_a_ramp_step)
    );

    grc_rail #(
        .STEP_W (STEP_CNT_W)
    ) u_rail_b (
        .clk         (clk),
        .rstn        (rstn),
        .wr_en       (wr_rail_b),
        .wr_data     (bus_req.wdata),
        .pin_act     (pin_act),
        .slew_code   (control_r[CTL_SLEW_B_MSB:CTL_SLEW_B_LSB]),
        .ctrl        (rail_b_ctrl),
        .pulldown_on (rail_b_pulldown_on),
        .ramp_step   (rail_b_ramp_step)
    );

    assign rail_a_on           = rail_a_ctrl.on;
    assign rail_a_volt_set_sel = rail_a_ctrl.volt_set_sel;
    assign rail_b_on           = rail_b_ctrl.on;
    assign rail_b_volt_set_sel = rail_b_ctrl.volt_set_sel;

    // Read selection; the status word shows the conditioned pin levels.
    assign rdata_nxt =
        (bus_req.addr == OFF_STATUS)   ? {{STATUS_PAD{1'b0}}, pin_lvl} :
        (bus_req.addr == OFF_CONTROL)  ? control_r :
        (bus_req.addr == OFF_PINS_0_1) ? pins01_r :
        (bus_req.addr == OFF_PINS_2_3) ? pins23_r :
        (bus_req.addr == OFF_PIN_4)    ? {{PIN4_PAD{1'b0}}, pin4_r} :
        (bus_req.addr == OFF_RAIL_A)   ? 8'(rail_a_ctrl) :
        (bus_req.addr == OFF_RAIL_B)   ? 8'(rail_b_ctrl) :
                                         RD_UNMAPPED;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= RD_UNMAPPED;
        end else if (bus_req.re) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

// ===== grc_pkg.sv
package grc_pkg;

    // Register byte addresses on the serial control interface.
    localparam logic [7:0] OFF_STATUS    = 8'h50;
    localparam logic [7:0] OFF_CONTROL   = 8'h56;
    localparam logic [7:0] OFF_PINS_0_1  = 8'h58;
    localparam logic [7:0] OFF_PINS_2_3  = 8'h59;
    localparam logic [7:0] OFF_PIN_4     = 8'h5A;
    localparam logic [7:0] OFF_RAIL_A    = 8'h5D;
    localparam logic [7:0] OFF_RAIL_B    = 8'h5E;

    localparam logic [7:0] RST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_PINS      = 8'h00;
    localparam logic [3:0] RST_PIN_4     = 4'h0;
    localparam logic [7:0] RST_RAIL      = 8'h00;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    localparam int NUM_PINS   = 5;
    localparam int PIN_0      = 0;
    localparam int PIN_1      = 1;
    localparam int PIN_2      = 2;
    localparam int PIN_3      = 3;
    localparam int PIN_4      = 4;
    localparam int NIB_W      = 4;
    localparam int STATUS_PAD = 8 - NUM_PINS;
    localparam int PIN4_PAD   = 8 - NIB_W;

    // Field positions in the control register.
    localparam int CTL_DEB_LSB    = 0;
    localparam int CTL_DEB_MSB    = 2;
    localparam int CTL_SLEW_A_LSB = 3;
    localparam int CTL_SLEW_A_MSB = 4;
    localparam int CTL_SLEW_B_LSB = 5;
    localparam int CTL_SLEW_B_MSB = 6;

    // Pin function codes.
    localparam logic [1:0] FUNC_INPUT  = 2'h0;
    localparam logic [1:0] FUNC_TRACK  = 2'h1;
    localparam logic [1:0] FUNC_OD_OUT = 2'h2;
    localparam logic [1:0] FUNC_PP_OUT = 2'h3;

    // Pin selector codes for rail control.
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_P1   = 2'h1;
    localparam logic [1:0] SEL_P2   = 2'h2;
    localparam logic [1:0] SEL_P3   = 2'h3;

    // Timing.
    localparam real CLK_MHZ     = 25.0;
    localparam real DEB_T1_MS   = 0.1;
    localparam real DEB_T2_MS   = 1.0;
    localparam real DEB_T3_MS   = 10.0;
    localparam real DEB_T4_MS   = 50.0;
    localparam real DEB_T5_MS   = 250.0;
    localparam real DEB_T6_MS   = 500.0;
    localparam real DEB_T7_MS   = 1000.0;
    localparam int unsigned DEB_C1 = int'($ceil(DEB_T1_MS * 1000.0 * CLK_MHZ));
    localparam int unsigned DEB_C2 = int'($ceil(DEB_T2_MS * 1000.0 * CLK_MHZ));
    localparam int unsigned DEB_C3 = int'($ceil(DEB_T3_MS * 1000.0 * CLK_MHZ));
    localparam int unsigned DEB_C4 = int'($ceil(DEB_T4_MS * 1000.0 * CLK_MHZ));
    localparam int unsigned DEB_C5 = int'($ceil(DEB_T5_MS * 1000.0 * CLK_MHZ));
    localparam int unsigned DEB_C6 = int'($ceil(DEB_T6_MS * 1000.0 * CLK_MHZ));
    localparam int unsigned DEB_C7 = int'($ceil(DEB_T7_MS * 1000.0 * CLK_MHZ));
    localparam int DEB_CNT_W = 25;

    localparam real STEP_T0_US = 4.0;
    localparam real STEP_T1_US = 2.0;
    localparam real STEP_T2_US = 1.0;
    localparam real STEP_T3_US = 0.5;
    localparam int unsigned STEP_CYC [4] = '{
        int'($floor(STEP_T0_US * CLK_MHZ)),
        int'($floor(STEP_T1_US * CLK_MHZ)),
        int'($floor(STEP_T2_US * CLK_MHZ)),
        int'($floor(STEP_T3_US * CLK_MHZ))
    };
    localparam int STEP_CNT_W = 7;

    typedef logic [DEB_CNT_W-1:0] grc_deb_cnt_type;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } grc_bus_req_type;

    typedef struct packed {
        logic       mode;
        logic       polarity;
        logic [1:0] func;
    } grc_pin_cfg_type;

    typedef struct packed {
        logic       reserved;
        logic [1:0] volt_pin_sel;
        logic       volt_set_sel;
        logic       pulldown_off;
        logic [1:0] enable_pin_sel;
        logic       on;
    } grc_rail_ctrl_type;

    // Maps a two-bit selector onto a pin index; SEL_NONE returns index 0 and is gated by caller.
    function automatic int grc_pin_of(input logic [1:0] sel, input int p1, input int p2,
                                      input int p3);
        int idx;
        idx = 0;
        unique case (sel)
            SEL_NONE: idx = 0;
            SEL_P1:   idx = p1;
            SEL_P2:   idx = p2;
            SEL_P3:   idx = p3;
        endcase
        return idx;
    endfunction

endpackage

// ===== grc_debounce.sv
`timescale 1ns/1ns
module grc_debounce
    import grc_pkg::*;
#(
    parameter int CNT_W = DEB_CNT_W
)(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             pin_raw,
    input  wire logic             deb_on,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  level
);
    logic             sync1_r;
    logic             sync2_r;
    logic             level_r;
    logic [CNT_W-1:0] cnt_r;
    logic             same;
    logic             done;

    assign same  = sync2_r == level_r;
    // The level is taken once it has differed from the held value for limit cycles.
    assign done  = !deb_on || (limit == '0) || (cnt_r >= limit - CNT_W'(1));
    assign level = level_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            level_r <= 1'b0;
            cnt_r   <= '0;
        end else if (same) begin
            cnt_r   <= '0;
        end else if (done) begin
            level_r <= sync2_r;
            cnt_r   <= '0;
        end else begin
            cnt_r   <= cnt_r + CNT_W'(1);
        end
    end

endmodule

// ===== grc_rail.sv
`timescale 1ns/1ns
module grc_rail
    import grc_pkg::*;
#(
    parameter int STEP_W = STEP_CNT_W
)(
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                wr_en,
    input  wire logic [7:0]          wr_data,
    input  wire logic [NUM_PINS-1:0] pin_act,
    input  wire logic [1:0]          slew_code,
    output grc_rail_ctrl_type        ctrl,
    output logic                     pulldown_on,
    output logic                     ramp_step
);
    grc_rail_ctrl_type   ctrl_r;
    grc_rail_ctrl_type   ctrl_nxt;
    grc_rail_ctrl_type   wr_ctrl;
    logic [NUM_PINS-1:0] act_d_r;
    logic                armed_r;
    logic                pd_r;
    logic                step_r;
    logic [STEP_W-1:0]   step_cnt_r;
    logic [STEP_W-1:0]   step_last;
    int                  en_idx;
    int                  v_idx;
    logic                en_rise;
    logic                en_fall;
    logic                v_rise;
    logic                v_fall;
    logic                on_sw;
    logic                vsel_sw;

    assign wr_ctrl = grc_rail_ctrl_type'(wr_data);
    assign en_idx  = grc_pin_of(ctrl_r.enable_pin_sel, PIN_0, PIN_1, PIN_3);
    assign v_idx   = grc_pin_of(ctrl_r.volt_pin_sel, PIN_1, PIN_2, PIN_4);
    // Edges are ignored for the first cycle after reset so a pin resting active does not count.
    assign en_rise = armed_r && (ctrl_r.enable_pin_sel != SEL_NONE)
                     && pin_act[en_idx] && !act_d_r[en_idx];
    assign en_fall = armed_r && (ctrl_r.enable_pin_sel != SEL_NONE)
                     && !pin_act[en_idx] && act_d_r[en_idx];
    assign v_rise  = armed_r && (ctrl_r.volt_pin_sel != SEL_NONE)
                     && pin_act[v_idx] && !act_d_r[v_idx];
    assign v_fall  = armed_r && (ctrl_r.volt_pin_sel != SEL_NONE)
                     && !pin_act[v_idx] && act_d_r[v_idx];
    assign on_sw   = wr_en ? wr_ctrl.on : ctrl_r.on;
    assign vsel_sw = wr_en ? wr_ctrl.volt_set_sel : ctrl_r.volt_set_sel;

    // A pin edge in the same cycle as a write wins over the written bit.
    always_comb begin
        ctrl_nxt              = wr_en ? wr_ctrl : ctrl_r;
        ctrl_nxt.reserved     = 1'b0;
        ctrl_nxt.on           = en_rise ? 1'b1 : (en_fall ? 1'b0 : on_sw);
        ctrl_nxt.volt_set_sel = v_rise ? 1'b1 : (v_fall ? 1'b0 : vsel_sw);
    end

    assign step_last   = STEP_W'(STEP_CYC[slew_code] - 1);
    assign ctrl        = ctrl_r;
    assign pulldown_on = pd_r;
    assign ramp_step   = step_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r  <= grc_rail_ctrl_type'(RST_RAIL);
            act_d_r <= '0;
            armed_r <= 1'b0;
            pd_r    <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            act_d_r <= pin_act;
            armed_r <= 1'b1;
            pd_r    <= !ctrl_nxt.on && !ctrl_nxt.pulldown_off;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            step_cnt_r <= '0;
            step_r     <= 1'b0;
        end else if (step_cnt_r >= step_last) begin
            step_cnt_r <= '0;
            step_r     <= 1'b1;
        end else begin
            step_cnt_r <= step_cnt_r + STEP_W'(1);
            step_r     <= 1'b0;
        end
    end

endmodule

// ===== grc_host.sv
`timescale 1ns/1ns
module grc_host
    import grc_pkg::*;
(
    input  wire logic [4:0] ext,
    input  wire logic       p2_out,
    input  wire logic       p2_oe_n,
    input  wire logic       p3_out,
    input  wire logic       p3_oe_n,
    output logic [4:0]      pin
);
    // The host drives a shared pin only while the device has released it.
    assign pin[1:0] = ext[1:0];
    assign pin[2]   = p2_oe_n ? ext[2] : p2_out;
    assign pin[3]   = p3_oe_n ? ext[3] : p3_out;
    assign pin[4]   = ext[4];
endmodule

// ===== grc_props.sv
`timescale 1ns/1ns
module grc_props
    import grc_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input grc_bus_req_type bus_req,
    input wire logic [7:0] reg_rdata,
    input wire logic       pin2_out,
    input wire logic       pin2_oe_n,
    input wire logic       pin3_out,
    input wire logic       pin3_oe_n,
    input wire logic       rail_a_on,
    input wire logic       rail_a_pulldown_on,
    input wire logic       rail_a_ramp_step,
    input wire logic       rail_b_on,
    input wire logic       rail_b_volt_set_sel,
    input wire logic       rail_b_pulldown_on,
    input wire logic       rail_b_ramp_step
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // A pin edge in the same cycle would win, so the bench never mixes the two.
    rail_a_write_a: assert property (bus_req.we && bus_req.addr == OFF_RAIL_A |=>
        rail_a_on == $past(bus_req.wdata[0])) else $error("rail a enable write");
    rail_b_write_a: assert property (bus_req.we && bus_req.addr == OFF_RAIL_B |=>
        rail_b_on == $past(bus_req.wdata[0]) && rail_b_volt_set_sel == $past(bus_req.wdata[4]))
        else $error("rail b write");
    pd_write_a: assert property (bus_req.we && bus_req.addr == OFF_RAIL_B |=>
        rail_b_pulldown_on == !($past(bus_req.wdata[0]) || $past(bus_req.wdata[3])))
        else $error("rail b pull-down");
    pd_rail_on_a: assert property (rail_a_on |-> !rail_a_pulldown_on)
        else $error("pull-down on enabled rail");
    unmapped_read_a: assert property (bus_req.re && bus_req.addr == 8'h5B |=>
        reg_rdata == RD_UNMAPPED) else $error("unmapped read");
    read_hold_a: assert property (!bus_req.re |=> $stable(reg_rdata))
        else $error("read data moved");
    pp2_drive_a: assert property (pin2_out |-> !pin2_oe_n)
        else $error("pin 2 high undriven");
    pp3_drive_a: assert property (pin3_out |-> !pin3_oe_n)
        else $error("pin 3 high undriven");
    ramp_a_gap_a: assert property (rail_a_ramp_step |=> !rail_a_ramp_step [*8])
        else $error("rail a step too soon");
    ramp_b_gap_a: assert property (rail_b_ramp_step |=> !rail_b_ramp_step [*8])
        else $error("rail b step too soon");
endmodule
bind grc_top grc_props u_props (.*);

// ===== test_gpio_and_rail_control_regs.sv
`timescale 1ns/1ns
module test_gpio_and_rail_control_regs
    import grc_pkg::*;
;
    logic            clk;
    logic            rstn;
    grc_bus_req_type req;
    logic [4:0]      ext;
    logic [4:0]      pin;
    logic [7:0]      rdata;
    logic [3:0]      po;
    logic [1:0]      ron;
    logic [1:0]      rvs;
    logic [1:0]      rpd;
    logic [1:0]      stp;
    logic            trk;
    logic [3:0]      c;
    logic [1:0]      x;
    int              n;
    int              mismatches;
    int              samples_checked;
    logic [7:0]      ra [4] = '{OFF_PINS_2_3, OFF_PIN_4, OFF_RAIL_A, OFF_RAIL_B};
    logic [7:0]      rm [4] = '{8'hFF, 8'h0F, 8'h7F, 8'h7F};
    logic [7:0]      per [4] = '{8'h64, 8'h32, 8'h19, 8'h0C};
    // One short debounce unit keeps every code's wait well inside the run time.
    localparam int   DU = 4;
    int              dc [8] = '{0, DU, 2 * DU, 3 * DU, 4 * DU, 5 * DU, 6 * DU, 7 * DU};
    int              pe [4] = '{0, 0, 1, 3};
    int              pv [4] = '{0, 1, 2, 4};

    grc_top #(.DEB_CYC_1(DU), .DEB_CYC_2(2 * DU), .DEB_CYC_3(3 * DU), .DEB_CYC_4(4 * DU),
        .DEB_CYC_5(5 * DU), .DEB_CYC_6(6 * DU), .DEB_CYC_7(7 * DU)) DUT (
        .clk(clk), .rstn(rstn), .bus_req(req), .reg_rdata(rdata), .pin0_in(pin[0]),
        .pin1_in(pin[1]), .pin2_in(pin[2]), .pin2_out(po[1]), .pin2_oe_n(po[0]),
        .pin3_in(pin[3]), .pin3_out(po[3]), .pin3_oe_n(po[2]), .pin4_in(pin[4]),
        .track_en(trk), .rail_a_on(ron[0]), .rail_a_volt_set_sel(rvs[0]),
        .rail_a_pulldown_on(rpd[0]), .rail_a_ramp_step(stp[0]), .rail_b_on(ron[1]),
        .rail_b_volt_set_sel(rvs[1]), .rail_b_pulldown_on(rpd[1]), .rail_b_ramp_step(stp[1]));
    grc_host HOST (.ext(ext), .p2_out(po[1]), .p2_oe_n(po[0]), .p3_out(po[3]),
        .p3_oe_n(po[2]), .pin(pin));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        #1 cmp(rdata, exp);
    endtask
    // Pin changes land on an edge; the wait covers sync and rail update latency.
    task automatic pset(input int i, input logic v, input int w);
        @(posedge clk);
        ext[i] <= v;
        repeat (w) @(posedge clk);
        #1;
    endtask
    task automatic step(input int j, output int w);
        w = 0;
        do begin
            @(posedge clk);
            #1 w++;
        end while (stp[j] !== 1'b1 && w < 300);
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #2000000;
        mismatches++;
        close_out();
    end

    initial begin
        rstn = 1'b0;
        req = '0;
        ext = '0;
        mismatches = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(ra[i], 8'h00);
        for (int i = 0; i < 4; i++) wr(ra[i], 8'hFF);
        for (int i = 0; i < 4; i++) rd(ra[i], rm[i]);
        for (int i = 3; i >= 0; i--) wr(ra[i], 8'h00);
        rd(8'h5B, RD_UNMAPPED);
        wr(OFF_STATUS, 8'hFF);
        rd(OFF_STATUS, 8'h00);
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            x[1] = c[1:0] == FUNC_PP_OUT && c[3] == c[2];
            x[0] = !(c[1:0] == FUNC_PP_OUT || (c[1:0] == FUNC_OD_OUT && c[3] != c[2]));
            wr(OFF_PINS_2_3, {c, c});
            repeat (3) @(posedge clk);
            #1 cmp({4'h0, po}, {4'h0, x, x});
        end
        wr(OFF_PINS_2_3, 8'h44);
        wr(OFF_PINS_0_1, 8'h44);
        wr(OFF_PIN_4, 8'h04);
        for (int r = 0; r < 2; r++) begin
            for (int s = 1; s < 4; s++) begin
                wr(ra[2 + r], 8'(s << 1));
                pset(pe[s], 1'b1, 6);
                cmp({6'h0, ron[r], rpd[r]}, 8'h02);
                pset(pe[s], 1'b0, 6);
                cmp({6'h0, ron[r], rpd[r]}, 8'h01);
                wr(ra[2 + r], 8'(s << 5));
                pset(pv[s], 1'b1, 6);
                cmp({7'h0, rvs[r]}, 8'h01);
                pset(pv[s], 1'b0, 6);
                cmp({7'h0, rvs[r]}, 8'h00);
            end
            wr(ra[2 + r], 8'h00);
        end
        wr(OFF_PINS_0_1, 8'h40);
        wr(OFF_RAIL_A, 8'h02);
        pset(0, 1'b1, 6);
        cmp({7'h0, ron[0]}, 8'h00);
        pset(0, 1'b0, 6);
        cmp({7'h0, ron[0]}, 8'h01);
        wr(OFF_RAIL_A, 8'h00);
        wr(OFF_PINS_0_1, 8'h05);
        pset(0, 1'b1, 6);
        cmp({7'h0, trk}, 8'h01);
        wr(OFF_PINS_0_1, 8'hC4);
        pset(0, 1'b1, 3);
        cmp({7'h0, trk}, 8'h00);
        wr(OFF_RAIL_A, 8'h04);
        for (int k = 1; k < 8; k++) begin
            wr(OFF_CONTROL, 8'(k));
            pset(1, k[0], dc[k] / 2);
            cmp({7'h0, ron[0]}, {7'h0, !k[0]});
            repeat (dc[k] + 4) @(posedge clk);
            #1 cmp({7'h0, ron[0]}, {7'h0, k[0]});
        end
        pset(1, 1'b0, 10);
        pset(1, 1'b1, 40);
        cmp({7'h0, ron[0]}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(OFF_CONTROL, 8'(k * 40));
            step(0, n);
            step(0, n);
            cmp(8'(n), per[k]);
            step(1, n);
            step(1, n);
            cmp(8'(n), per[k]);
        end
        close_out();
    end
endmodule
